// ### src/mmc_misc_regs.sv
// Interrupt mask, lost packet counter, serial EEPROM port and timer register bank
//
// Implementation choice: the address-and-strobe port.
module mmc_misc_regs
  import mmc_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TMR_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             rst_n_i,
  // Register bus
  input  wire mmc_bus_req_t     bus_i,
  output logic      [31:0]      rdata_o,
  // MAC events
  input  wire mmc_events_t      events_i,
  input  wire logic             rx_drop_i,
  // Serial EEPROM
  output mmc_eeprom_pins_t      eeprom_o,
  input  wire logic             eeprom_dout_i,
  // Interrupt
  output logic                  irq_o
);
  function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] off);
    return a == off;
  endfunction

  logic [31:0]       irq_mask_q;
  logic [31:0]       irq_stat_q;
  logic [31:0]       evt_vec;
  logic [31:0]       en_vec;
  logic [LOST_W-1:0] lost_cnt_q;
  logic              lost_ovf_q;
  logic [31:0]       ee_ctrl_q;
  logic              ee_so_sync;
  logic              ee_any;
  logic              ee_read_ok;
  logic              tmr_repeat_q;
  logic [TMR_W-1:0]  tmr_count;
  logic              tmr_expired;
  logic [31:0]       rd_mux;
  logic              wr_mask;
  logic              wr_stat;
  logic              wr_ee;
  logic              wr_tmr;
  logic              rd_lost;

  assign wr_mask = bus_i.wr && hit(bus_i.addr, OFF_IRQ_MASK);
  assign wr_stat = bus_i.wr && hit(bus_i.addr, OFF_IRQ_STAT);
  assign wr_ee   = bus_i.wr && hit(bus_i.addr, OFF_EEPROM);
  assign wr_tmr  = bus_i.wr && hit(bus_i.addr, OFF_TIMER);
  assign rd_lost = bus_i.rd && hit(bus_i.addr, OFF_LOST_COUNT);

  // Interrupt mask register
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      irq_mask_q <= IRQ_MASK_RESET;
    end else if (wr_mask) begin
      irq_mask_q <= bus_i.wdata & MASK_WR_BITS;
    end
  end

  // Event vector in status layout
  always_comb begin
    evt_vec          = '0;
    evt_vec[IRQ_FBE] = events_i.bus_fault;
    evt_vec[IRQ_GPT] = tmr_expired;
    evt_vec[IRQ_RWT] = events_i.rx_watchdog;
    evt_vec[IRQ_RS]  = events_i.rx_stopped;
    evt_vec[IRQ_RU]  = events_i.rx_no_desc;
    evt_vec[IRQ_RC]  = events_i.rx_done;
    evt_vec[IRQ_TU]  = events_i.tx_underflow;
    evt_vec[IRQ_TJ]  = events_i.tx_jabber;
    evt_vec[IRQ_TDU] = events_i.tx_no_desc;
    evt_vec[IRQ_TPS] = events_i.tx_stopped;
    evt_vec[IRQ_TC]  = events_i.tx_done;
  end

  // Sticky status, write one to clear, a new event wins over the clear
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~(wr_stat ? bus_i.wdata : 32'h0000_0000)) | evt_vec;
    end
  end

  // Individual enables gated by the class master enables
  always_comb begin
    en_vec = '0;
    if (irq_mask_q[BIT_NORM_EN]) begin
      en_vec = en_vec | (irq_mask_q & NORMAL_BITS); // [RQ1] [RQ7]
    end
    if (irq_mask_q[BIT_ABN_EN]) begin
      en_vec = en_vec | (irq_mask_q & ABNORMAL_BITS); // [RQ2] [RQ3] [RQ4] [RQ5] [RQ6]
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_q & en_vec); // [RQ1] [RQ2]
    end
  end

  // Lost packet counter, read clears, a drop in the read cycle is kept
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      lost_cnt_q <= '0;
    end else if (rd_lost) begin
      lost_cnt_q <= rx_drop_i ? LOST_W'(1) : '0; // [RQ8]
    end else if (rx_drop_i) begin
      lost_cnt_q <= lost_cnt_q + LOST_W'(1); // [RQ8]
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      lost_ovf_q <= 1'b0;
    end else if (rd_lost) begin
      lost_ovf_q <= 1'b0; // [RQ9]
    end else if (rx_drop_i && (&lost_cnt_q)) begin
      lost_ovf_q <= 1'b1; // [RQ9]
    end
  end

  // Serial EEPROM control bits
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ee_ctrl_q <= EE_RESET;
    end else if (wr_ee) begin
      ee_ctrl_q <= bus_i.wdata & EE_WR_BITS; // [RQ12]
    end
  end

  mmc_sync2 #(
    .RST_VAL (EE_SO_IDLE)
  ) u_so_sync (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .async_i    (eeprom_dout_i),
    .sync_o     (ee_so_sync)
  );

  assign ee_any     = ee_ctrl_q[EE_SEL] && (ee_ctrl_q[EE_RD_EN] || ee_ctrl_q[EE_WR_EN]); // [RQ10]
  assign ee_read_ok = ee_ctrl_q[EE_SEL] && ee_ctrl_q[EE_RD_EN]; // [RQ10]

  // EEPROM pins follow their bits while access is enabled
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      eeprom_o <= '0;
    end else begin
      eeprom_o.chip_select <= ee_any && ee_ctrl_q[EE_CS]; // [RQ16] [RQ10]
      eeprom_o.sclk        <= ee_any && ee_ctrl_q[EE_CLK]; // [RQ16] [RQ10]
      eeprom_o.serial_in   <= ee_any && ee_ctrl_q[EE_SI]; // [RQ11] [RQ16]
    end
  end

  // Timer configuration
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      tmr_repeat_q <= 1'b0;
    end else if (wr_tmr) begin
      tmr_repeat_q <= bus_i.wdata[TMR_REPEAT_BIT]; // [RQ14]
    end
  end

  mmc_gp_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .load_i     (wr_tmr),
    .load_val_i (bus_i.wdata[TMR_W-1:0]),
    .repeat_i   (tmr_repeat_q),
    .count_o    (tmr_count),
    .expired_o  (tmr_expired)
  );

  // Read multiplexer, unmapped addresses read zero
  always_comb begin
    rd_mux = '0;
    if (hit(bus_i.addr, OFF_IRQ_MASK)) begin
      rd_mux = irq_mask_q;
    end else if (hit(bus_i.addr, OFF_IRQ_STAT)) begin
      rd_mux = irq_stat_q;
    end else if (hit(bus_i.addr, OFF_LOST_COUNT)) begin
      rd_mux[LOST_W-1:0]  = lost_cnt_q; // [RQ8]
      rd_mux[LOST_OVF_BIT] = lost_ovf_q; // [RQ9]
    end else if (hit(bus_i.addr, OFF_EEPROM)) begin
      rd_mux         = ee_ctrl_q;
      rd_mux[EE_SO]  = ee_read_ok ? ee_so_sync : EE_SO_IDLE; // [RQ11] [RQ16]
    end else if (hit(bus_i.addr, OFF_TIMER)) begin
      rd_mux[TMR_W-1:0]     = tmr_count;
      rd_mux[TMR_REPEAT_BIT] = tmr_repeat_q;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= bus_i.rd ? rd_mux : 32'h0000_0000;
    end
  end

  AST_NORMAL_IRQ: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RQ1]
    (irq_stat_q[IRQ_TC] && irq_mask_q[IRQ_TC] && irq_mask_q[BIT_NORM_EN]) |=> irq_o)
    else $error("Enabled transmit done did not raise interrupt");
  AST_NORMAL_OFF: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RQ7]
    (!irq_mask_q[BIT_NORM_EN] && !irq_mask_q[BIT_ABN_EN]) |=> !irq_o)
    else $error("Interrupt raised with both master enables clear");
  AST_ABNORMAL_GATE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RQ2]
    (!irq_mask_q[BIT_NORM_EN] && ((irq_stat_q & ABNORMAL_BITS) != '0) && irq_mask_q[BIT_ABN_EN]
     && ((irq_mask_q & irq_stat_q & ABNORMAL_BITS) != '0)) |=> irq_o)
    else $error("Enabled abnormal event did not raise interrupt");
  AST_FBE_IRQ: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RQ3]
    (events_i.bus_fault && irq_mask_q[IRQ_FBE] && irq_mask_q[BIT_ABN_EN] && !wr_mask)
     |=> ##1 irq_o)
    else $error("Bus fault did not raise interrupt in two cycles");
  AST_GPT_STAT: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RQ4]
    tmr_expired |=> irq_stat_q[IRQ_GPT])
    else $error("Timer expiry not recorded");
  AST_RX_ABN: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RQ5]
    (irq_stat_q[IRQ_RS] && irq_mask_q[IRQ_RS] && !irq_mask_q[BIT_ABN_EN]
     && ((irq_stat_q & en_vec) == '0)) |=> !irq_o)
    else $error("Receive stopped raised interrupt without abnormal enable");
  AST_TX_ABN: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RQ6]
    (irq_stat_q[IRQ_TU] && irq_mask_q[IRQ_TU] && irq_mask_q[BIT_ABN_EN]) |=> irq_o)
    else $error("Transmit underflow did not raise interrupt");
  AST_LOST_INC: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RQ8]
    (rx_drop_i && !rd_lost) |=> lost_cnt_q == $past(lost_cnt_q) + LOST_W'(1))
    else $error("Lost packet count did not increment");
  AST_LOST_CLR: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RQ9]
    (rd_lost && !rx_drop_i) |=> (lost_cnt_q == '0) && !lost_ovf_q
     && rdata_o[LOST_OVF_BIT] == $past(lost_ovf_q))
    else $error("Read did not clear lost count and overflow");
  AST_LOST_OVF: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RQ9]
    (rx_drop_i && !rd_lost && (&lost_cnt_q)) |=> lost_ovf_q && (lost_cnt_q == '0))
    else $error("Overflow flag not set on wrap");
  AST_EE_GATE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RQ10]
    !ee_ctrl_q[EE_SEL] |=> !eeprom_o.chip_select && !eeprom_o.sclk)
    else $error("EEPROM driven without select");
  AST_EE_DIN: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RQ11]
    ee_any |=> eeprom_o.serial_in == $past(ee_ctrl_q[EE_SI]))
    else $error("EEPROM serial input does not follow its bit");
  AST_EE_SO: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RQ16]
    (bus_i.rd && hit(bus_i.addr, OFF_EEPROM) && ee_read_ok)
     |=> rdata_o[EE_SO] == $past(ee_so_sync))
    else $error("EEPROM output bit does not show synchronised pin");

  COV_IRQ_RISE: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !irq_o ##1 irq_o);
  COV_LOST_OVF: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    rx_drop_i && (&lost_cnt_q));
  COV_EE_READ: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    bus_i.rd && hit(bus_i.addr, OFF_EEPROM) && ee_read_ok);
endmodule

// ### src/mmc_pkg.sv
// Register map, field positions, timing constants and carrier types of the misc control bank
// Behaviour
// RQ1 - Bit 16 enables every normal interrupt
// RQ2 - Bit 15 enables every abnormal interrupt
// RQ3 - Bus fault interrupt needs bit 13 and abnormal
// RQ4 - Timer interrupt needs bit 11 and abnormal
// RQ5 - Rx watchdog, stopped, no-descriptor need abnormal enable
// RQ6 - Tx underflow, jabber, stopped need abnormal enable
// RQ7 - Rx done, tx no-descriptor, tx done need normal
// RQ8 - Count dropped packets in sixteen bits, read clears
// RQ9 - Sticky overflow flag at bit 16, read clears
// RQ10 - EEPROM access only while select bit 11 set
// RQ11 - Bit 3 shows EEPROM output, bit 2 drives input
// RQ12 - Software toggles clock bit, sets chip select
// RQ13 - Sixteen bit timer counts down every 204 us
// RQ14 - Repeat bit keeps the timer running continuously
// RQ15 - Timer at zero flags expiry, reloads if repeating
// RQ16 - EEPROM pins follow bits, output bit synchronised
package mmc_pkg;

  // Register bus
  localparam int unsigned AW = 8;
  localparam logic [AW-1:0] OFF_IRQ_STAT   = 8'h3c;
  localparam logic [AW-1:0] OFF_IRQ_MASK   = 8'h38;
  localparam logic [AW-1:0] OFF_LOST_COUNT = 8'h40;
  localparam logic [AW-1:0] OFF_EEPROM     = 8'h48;
  localparam logic [AW-1:0] OFF_TIMER      = 8'h58;

  // Interrupt mask and status fields
  localparam int unsigned BIT_NORM_EN = 16;
  localparam int unsigned BIT_ABN_EN  = 15;
  localparam int unsigned IRQ_FBE = 13;
  localparam int unsigned IRQ_GPT = 11;
  localparam int unsigned IRQ_RWT = 9;
  localparam int unsigned IRQ_RS  = 8;
  localparam int unsigned IRQ_RU  = 7;
  localparam int unsigned IRQ_RC  = 6;
  localparam int unsigned IRQ_TU  = 5;
  localparam int unsigned IRQ_TJ  = 3;
  localparam int unsigned IRQ_TDU = 2;
  localparam int unsigned IRQ_TPS = 1;
  localparam int unsigned IRQ_TC  = 0;
  localparam logic [31:0] NORMAL_BITS    = 32'h0000_0045;
  localparam logic [31:0] ABNORMAL_BITS  = 32'h0000_2baa;
  localparam logic [31:0] MASK_WR_BITS   = 32'h0001_abef;
  localparam logic [31:0] IRQ_MASK_RESET = 32'h0000_0000;

  // Lost packet counter
  localparam int unsigned LOST_OVF_BIT = 16;
  localparam int unsigned LOST_W       = 16;

  // Serial EEPROM port
  localparam int unsigned EE_RD_EN  = 14;
  localparam int unsigned EE_WR_EN  = 13;
  localparam int unsigned EE_SEL    = 11;
  localparam int unsigned EE_SO     = 3;
  localparam int unsigned EE_SI     = 2;
  localparam int unsigned EE_CLK    = 1;
  localparam int unsigned EE_CS     = 0;
  localparam logic [31:0] EE_WR_BITS = 32'h0000_6807;
  localparam logic [31:0] EE_RESET   = 32'h0000_0007;
  localparam logic        EE_SO_IDLE = 1'b1;

  // General purpose timer
  localparam int unsigned TMR_REPEAT_BIT = 16;
  localparam int unsigned TMR_W          = 16;
  localparam int unsigned CLK_PERIOD_NS  = 25;
  localparam int unsigned TMR_TICK_NS    = 204000;
  localparam int unsigned TMR_TICK_CYCLES = TMR_TICK_NS / CLK_PERIOD_NS;

  // Register bus request
  typedef struct packed {
    logic [AW-1:0] addr;
    logic [31:0]   wdata;
    logic          wr;
    logic          rd;
  } mmc_bus_req_t;

  // Event pulses from the MAC, same clock
  typedef struct packed {
    logic bus_fault;
    logic rx_watchdog;
    logic rx_stopped;
    logic rx_no_desc;
    logic rx_done;
    logic tx_underflow;
    logic tx_jabber;
    logic tx_no_desc;
    logic tx_stopped;
    logic tx_done;
  } mmc_events_t;

  // Serial EEPROM output pins
  typedef struct packed {
    logic chip_select;
    logic sclk;
    logic serial_in;
  } mmc_eeprom_pins_t;

endpackage

// ### src/mmc_sync2.sv
// Two flip-flop synchroniser for a single level
module mmc_sync2
  import mmc_pkg::*;
#(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  // Level
  input  wire logic async_i,
  output logic      sync_o
);
  logic meta_q;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      meta_q <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule

// ### src/mmc_gp_timer.sv
// General purpose down-counting timer with tick divider and repeat mode
module mmc_gp_timer
  import mmc_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TMR_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             rst_n_i,
  // Control
  input  wire logic             load_i,
  input  wire logic [TMR_W-1:0] load_val_i,
  input  wire logic             repeat_i,
  // Status
  output logic      [TMR_W-1:0] count_o,
  output logic                  expired_o
);
  localparam int unsigned CW = $clog2(TICK_CYCLES + 1);

  typedef enum logic [1:0] {
    T_IDLE = 2'b01,
    T_RUN  = 2'b10
  } mmc_tmr_state_t;

  mmc_tmr_state_t   state_q;
  logic [CW-1:0]    div_q;
  logic [TMR_W-1:0] reload_q;
  logic             tick;
  logic             hit_zero;

  assign tick     = (state_q == T_RUN) && (div_q == CW'(TICK_CYCLES - 1));
  assign hit_zero = tick && (count_o == TMR_W'(1));

  // Tick divider, restarted by every load
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || load_i || state_q != T_RUN || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + CW'(1);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state_q   <= T_IDLE;
      count_o   <= '0;
      reload_q  <= '0;
      expired_o <= 1'b0;
    end else begin
      expired_o <= hit_zero; // [RQ15]
      if (load_i) begin
        reload_q <= load_val_i;
        count_o  <= load_val_i; // [RQ13]
        state_q  <= (load_val_i != '0) ? T_RUN : T_IDLE;
      end else begin
        unique case (state_q)
          T_IDLE: state_q <= T_IDLE;
          T_RUN: begin
            if (hit_zero && repeat_i) begin
              count_o <= reload_q; // [RQ14] [RQ15]
            end else if (hit_zero) begin
              count_o <= '0;
              state_q <= T_IDLE; // [RQ15]
            end else if (tick) begin
              count_o <= count_o - TMR_W'(1); // [RQ13]
            end
          end
          default: state_q <= T_IDLE;
        endcase
      end
    end
  end

  AST_TMR_DEC: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RQ13]
    (tick && !load_i && count_o > TMR_W'(1)) |=> count_o == $past(count_o) - TMR_W'(1))
    else $error("Timer did not decrement on tick");
  AST_TMR_REPEAT: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RQ14]
    (hit_zero && repeat_i && !load_i) |=> (state_q == T_RUN) && count_o == $past(reload_q) && expired_o)
    else $error("Repeat mode did not reload timer");
  AST_TMR_ONESHOT: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RQ15]
    (hit_zero && !repeat_i && !load_i) |=> (state_q == T_IDLE) && expired_o ##1 !expired_o)
    else $error("One-shot timer did not stop with one expiry");
  COV_TMR_REPEAT: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    hit_zero && repeat_i);
endmodule

// ### sim/mmc_eeprom_model.sv
// Behavioural serial EEPROM that echoes the last bit clocked into it
module mmc_eeprom_model
  import mmc_pkg::*;
(
  // Pins from the block
  input  wire mmc_eeprom_pins_t pins_i,
  // Serial output
  output logic                  dout_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] shift_q;

  initial shift_q = 16'h0000;

  // Shift in on each rising serial clock while selected
  always @(posedge pins_i.sclk) begin
    if (pins_i.chip_select) begin
      shift_q <= {shift_q[14:0], pins_i.serial_in};
    end
  end

  // Output pulled high while deselected
  assign dout_o = pins_i.chip_select ? shift_q[0] : 1'b1;
endmodule

// ### sim/testbench.sv
// Self-checking bench of the misc control register bank
module testbench
  import mmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned TICK   = 8;
  localparam int          EVB[10] = '{0, 1, 2, 3, 5, 6, 7, 8, 9, 13};

  logic             core_clk_i;
  logic             rst_n_i;
  logic             drop;
  logic             dout;
  logic             irq;
  logic [31:0]      rdata;
  mmc_bus_req_t     bus;
  mmc_events_t      ev;
  mmc_eeprom_pins_t pins;
  int               miscompares;
  int               n_checks;
  int               cycles;
  int               b;
  int               good;
  int               bad;

  mmc_misc_regs #(.TICK_CYCLES(TICK)) dut_u (
    .core_clk_i    (core_clk_i),
    .rst_n_i       (rst_n_i),
    .bus_i         (bus),
    .rdata_o       (rdata),
    .events_i      (ev),
    .rx_drop_i     (drop),
    .eeprom_o      (pins),
    .eeprom_dout_i (dout),
    .irq_o         (irq)
  );

  mmc_eeprom_model eeprom_u (
    .pins_i (pins),
    .dout_o (dout)
  );

  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  task automatic conclude();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk_i);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk_i);
    bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk_i);
    bus.rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  task automatic pulse(input logic [9:0] e);
    @(posedge core_clk_i);
    ev <= mmc_events_t'(e);
    @(posedge core_clk_i);
    ev <= mmc_events_t'(10'h000);
  endtask

  task automatic wait_irq();
    int i;
    i = 0;
    while (irq !== 1'b1 && i < 60) begin
      idle(1);
      i++;
    end
    chk({31'h0, irq}, 32'h1);
  endtask

  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      miscompares++;
      conclude();
    end
  end

  initial begin
    rst_n_i     = 1'b0;
    bus         = '0;
    ev          = '0;
    drop        = 1'b0;
    miscompares = 0;
    n_checks    = 0;
    cycles      = 0;
    repeat (16) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    // Reset values and plain accesses
    rd(OFF_IRQ_MASK, IRQ_MASK_RESET);
    rd(OFF_IRQ_STAT, 32'h0);
    rd(OFF_LOST_COUNT, 32'h0);
    rd(OFF_EEPROM, 32'h0000_000f);
    rd(OFF_TIMER, 32'h0);
    chk({29'h0, pins}, 32'h0);
    wr(OFF_IRQ_MASK, 32'hffff_ffff);
    rd(OFF_IRQ_MASK, MASK_WR_BITS);
    wr(8'h44, 32'hffff_ffff);
    rd(8'h44, 32'h0);
    $display("test registers done");
    // Every event against its own and the other master enable
    for (int i = 0; i < 10; i++) begin
      b    = EVB[i];
      good = NORMAL_BITS[b] ? BIT_NORM_EN : BIT_ABN_EN;
      bad  = NORMAL_BITS[b] ? BIT_ABN_EN : BIT_NORM_EN;
      wr(OFF_IRQ_MASK, (32'h1 << b) | (32'h1 << bad));
      pulse(10'h001 << i);
      idle(3);
      chk({31'h0, irq}, 32'h0);
      rd(OFF_IRQ_STAT, 32'h1 << b);
      wr(OFF_IRQ_MASK, (32'h1 << b) | (32'h1 << good));
      idle(3);
      chk({31'h0, irq}, 32'h1);
      wr(OFF_IRQ_MASK, 32'h1 << good);
      idle(3);
      chk({31'h0, irq}, 32'h0);
      wr(OFF_IRQ_MASK, (32'h1 << b) | (32'h1 << good));
      wr(OFF_IRQ_STAT, 32'h1 << b);
      idle(3);
      chk({31'h0, irq}, 32'h0);
      rd(OFF_IRQ_STAT, 32'h0);
    end
    pulse(10'h200);
    idle(3);
    chk({31'h0, irq}, 32'h1);
    wr(OFF_IRQ_STAT, 32'h1 << IRQ_FBE);
    $display("test interrupts done");
    // Lost packets: a few, then a full wrap
    repeat (3) pulse(10'h000);
    @(posedge core_clk_i);
    drop <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    drop <= 1'b0;
    rd(OFF_LOST_COUNT, 32'h0000_0003);
    rd(OFF_LOST_COUNT, 32'h0);
    @(posedge core_clk_i);
    drop <= 1'b1;
    repeat (65537) @(posedge core_clk_i);
    drop <= 1'b0;
    rd(OFF_LOST_COUNT, 32'h0001_0001);
    rd(OFF_LOST_COUNT, 32'h0);
    $display("test lost count done");
    // Serial EEPROM port
    wr(OFF_EEPROM, 32'h0000_4803);
    idle(1);
    chk({29'h0, pins}, 32'h6);
    wr(OFF_EEPROM, 32'h0000_0007);
    idle(1);
    chk({29'h0, pins}, 32'h0);
    wr(OFF_EEPROM, 32'h0000_2807);
    idle(1);
    chk({29'h0, pins}, 32'h7);
    rd(OFF_EEPROM, 32'h0000_280f);
    foreach (EVB[i]) begin
      b = (32'h0000_002d >> (i % 6)) & 1;
      wr(OFF_EEPROM, 32'h0000_4801 | (b << 2));
      wr(OFF_EEPROM, 32'h0000_4803 | (b << 2));
      idle(1);
      chk({29'h0, pins}, 32'h6 | b);
      idle(3);
      rd(OFF_EEPROM, 32'h0000_4803 | (b << 2) | (b << 3));
    end
    $display("test eeprom done");
    // Timer single shot, then repeat mode
    wr(OFF_IRQ_MASK, (32'h1 << IRQ_GPT) | (32'h1 << BIT_ABN_EN));
    wr(OFF_TIMER, 32'h0000_0002);
    idle(TICK + 1);
    rd(OFF_TIMER, 32'h0000_0001);
    wait_irq();
    rd(OFF_TIMER, 32'h0);
    rd(OFF_IRQ_STAT, 32'h1 << IRQ_GPT);
    wr(OFF_IRQ_STAT, 32'h1 << IRQ_GPT);
    idle(3 * TICK);
    chk({31'h0, irq}, 32'h0);
    wr(OFF_TIMER, 32'h0001_0002);
    wait_irq();
    rd(OFF_TIMER, 32'h0001_0002);
    wr(OFF_IRQ_STAT, 32'h1 << IRQ_GPT);
    idle(3);
    chk({31'h0, irq}, 32'h0);
    wait_irq();
    wr(OFF_TIMER, 32'h0);
    wr(OFF_IRQ_STAT, 32'h1 << IRQ_GPT);
    idle(3);
    chk({31'h0, irq}, 32'h0);
    $display("test timer done");
    conclude();
  end
endmodule
